// >>> rcg_top.sv
// Reset source combining, reset stretching, module clock gating and bandgap control
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
module rcg_top #(
  parameter int unsigned TOUT_CYC_0 = rcg_pkg::TOUT_US_0 * 1000 / rcg_pkg::CLK_PERIOD_NS,
  parameter int unsigned TOUT_CYC_1 = rcg_pkg::TOUT_US_1 * 1000 / rcg_pkg::CLK_PERIOD_NS,
  parameter int unsigned TOUT_CYC_2 = rcg_pkg::TOUT_US_2 * 1000 / rcg_pkg::CLK_PERIOD_NS,
  parameter int unsigned TOUT_CYC_3 = rcg_pkg::TOUT_US_3 * 1000 / rcg_pkg::CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  output logic [7:0] bus_rdata,
  input wire logic power_low,
  input wire logic ext_reset_n,
  input wire logic external_reset_disable_fuse,
  input wire logic brownout_low,
  input wire logic [2:0] brownout_level_fuse,
  input wire logic [1:0] startup_time_fuse,
  input wire logic [3:0] clock_select_fuse,
  input wire logic watchdog_expire,
  input wire logic watchdog_reset_mode,
  input wire logic timer_two_async_select,
  input wire logic comparator_bandgap_select,
  input wire logic converter_enable,
  output rcg_pkg::rcg_gate_t clk_en,
  output logic converter_shutdown,
  output logic comparator_mux_allow,
  output logic bandgap_power,
  output logic internal_reset,
  output logic port_reset,
  output logic fetch_start
);
  localparam int CW = rcg_pkg::CNT_W;

  logic por_sync, ext_low, brown_low;
  logic wdt_src_reg, wdt_src_next;
  logic [CW-1:0] start_len, len_sel, cnt_reg, cnt_next;
  logic internal_reset_reg, internal_reset_next;
  logic port_reset_reg, fetch_start_reg;
  logic [7:0] gate_reg, gate_next;
  logic wdt_flag_reg, wdt_flag_next;
  logic [7:0] rdata_reg, rdata_next;
  rcg_pkg::rcg_gate_t clk_en_reg, clk_en_next;
  logic conv_shut_reg, mux_allow_reg, bandgap_reg;

  // Source conditioning: the supply, pin and brownout sources cross in through three stages; the watchdog pulse is registered once
  wire ext_pin_low = !ext_reset_n;
  rcg_filter #(.MIN_CYC(rcg_pkg::POR_MIN_CYC)) u_por_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .raw_in(power_low),
    .active(por_sync)
  );
  rcg_filter #(.MIN_CYC(rcg_pkg::EXT_MIN_CYC)) u_ext_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .raw_in(ext_pin_low),
    .active(ext_low)
  );
  rcg_filter #(.MIN_CYC(rcg_pkg::BROWN_MIN_CYC)) u_brown_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .raw_in(brownout_low),
    .active(brown_low)
  );

  // Qualified sources
  wire brown_enabled = brownout_level_fuse != rcg_pkg::BROWN_FUSE_OFF;
  wire ext_src = ext_low && !external_reset_disable_fuse;
  wire brown_src = brown_low && brown_enabled;
  assign wdt_src_next = watchdog_expire && watchdog_reset_mode;
  wire any_src = por_sync | ext_src | wdt_src_reg | brown_src;

  // Async path for the ports; a clockless pin pulse still reaches them
  wire port_async_hit = power_low | (ext_pin_low & !external_reset_disable_fuse);

  // Delay length chosen by the start-up fuse, plus oscillator start for some clocks
  always_comb begin
    unique case (startup_time_fuse)
      2'h0: start_len = CW'(TOUT_CYC_0);
      2'h1: start_len = CW'(TOUT_CYC_1);
      2'h2: start_len = CW'(TOUT_CYC_2);
      2'h3: start_len = CW'(TOUT_CYC_3);
    endcase
  end
  assign len_sel = start_len + (clock_select_fuse[0] ? rcg_pkg::OSC_LEN : '0);

  // Counter restarts on any source; compare with less-than so a fuse change cannot hang it
  assign cnt_next = any_src ? '0 : (cnt_reg < len_sel) ? cnt_reg + 1'b1 : cnt_reg;
  assign internal_reset_next = any_src | (cnt_reg < len_sel);

  // Watchdog pulse register; counting starts on the cycle after it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdt_src_reg <= 1'b0;
    end else begin
      wdt_src_reg <= wdt_src_next;
    end
  end

  // Delay counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Internal reset; a supply drop sets it without waiting for an edge
  always_ff @(posedge clk or posedge power_low) begin
    if (power_low) begin
      internal_reset_reg <= 1'b1;
    end else if (sys_rst) begin
      internal_reset_reg <= 1'b1;
    end else begin
      internal_reset_reg <= internal_reset_next;
    end
  end

  // Port reset; glitches on the pin may tri-state ports briefly, which is harmless
  always_ff @(posedge clk or posedge port_async_hit) begin
    if (port_async_hit) begin
      port_reset_reg <= 1'b1;
    end else if (sys_rst) begin
      port_reset_reg <= 1'b1;
    end else begin
      port_reset_reg <= internal_reset_next;
    end
  end

  // One-cycle fetch restart at the release of the internal reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fetch_start_reg <= 1'b0;
    end else begin
      fetch_start_reg <= internal_reset_reg && !internal_reset_next;
    end
  end

  // Register decode
  wire reg_rst = sys_rst | internal_reset_reg;
  wire gate_sel = bus_addr == rcg_pkg::GATE_OFFSET;
  wire status_sel = bus_addr == rcg_pkg::STATUS_OFFSET;
  wire gate_we = bus_we && gate_sel;
  wire status_we = bus_we && status_sel;
  assign gate_next = gate_we ? (bus_wdata & rcg_pkg::GATE_WMASK) : gate_reg;

  // Flag: a watchdog pulse wins over a clearing write in the same cycle
  assign wdt_flag_next = wdt_src_reg ? 1'b1 :
                         (status_we && !bus_wdata[rcg_pkg::WDT_FLAG_BIT]) ? 1'b0 :
                         wdt_flag_reg;
  wire [7:0] status_rd = 8'(wdt_flag_reg) << rcg_pkg::WDT_FLAG_BIT;

  // Read mux, unmapped addresses answer zero
  wire [7:0] rd_sel = gate_sel ? gate_reg : status_sel ? status_rd : rcg_pkg::READ_IDLE;
  assign rdata_next = bus_re ? rd_sel : rcg_pkg::READ_IDLE;

  // Per-peripheral enables; a low enable also locks out its register access
  assign clk_en_next.two_wire = !gate_next[rcg_pkg::GATE_TWO_WIRE_BIT] | reg_rst;
  assign clk_en_next.timer_two = !(gate_next[rcg_pkg::GATE_TIMER_TWO_BIT] &&
                                   !timer_two_async_select) | reg_rst;
  assign clk_en_next.timer_zero = !gate_next[rcg_pkg::GATE_TIMER_ZERO_BIT] | reg_rst;
  assign clk_en_next.timer_one = !gate_next[rcg_pkg::GATE_TIMER_ONE_BIT] | reg_rst;
  assign clk_en_next.serial_peripheral =
    !gate_next[rcg_pkg::GATE_SERIAL_PERIPHERAL_BIT] | reg_rst;
  assign clk_en_next.serial_port = !gate_next[rcg_pkg::GATE_SERIAL_PORT_BIT] | reg_rst;
  // Converter gate assumes software already stopped the converter
  wire conv_gate_next = gate_next[rcg_pkg::GATE_CONVERTER_BIT] && !reg_rst;

  // Gate register and derived enables, all reset by the internal reset
  always_ff @(posedge clk) begin
    if (reg_rst) begin
      gate_reg <= rcg_pkg::GATE_RESET;
    end else begin
      gate_reg <= gate_next;
    end
  end

  // Enables update with the register so the gated module stops in the same cycle
  always_ff @(posedge clk) begin
    clk_en_reg <= clk_en_next;
    conv_shut_reg <= conv_gate_next;
    mux_allow_reg <= !conv_gate_next;
  end

  // Flag survives watchdog and pin resets; only power-on or software clear it
  always_ff @(posedge clk) begin
    if (sys_rst || por_sync) begin
      wdt_flag_reg <= rcg_pkg::STATUS_RESET;
    end else begin
      wdt_flag_reg <= wdt_flag_next;
    end
  end

  // Read data stands one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= rcg_pkg::READ_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Bandgap follows its users with no reset, so it stays valid for the detector
  always_ff @(posedge clk) begin
    bandgap_reg <= brown_enabled | comparator_bandgap_select | converter_enable;
  end

  assign bus_rdata = rdata_reg;
  assign clk_en = clk_en_reg;
  assign converter_shutdown = conv_shut_reg;
  assign comparator_mux_allow = mux_allow_reg;
  assign bandgap_power = bandgap_reg;
  assign internal_reset = internal_reset_reg;
  assign port_reset = port_reset_reg;
  assign fetch_start = fetch_start_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_two_wire;
    gate_we && !reg_rst |=> clk_en.two_wire == !$past(bus_wdata[7]);
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("two-wire enable wrong");

  property p_timer_two;
    gate_we && !reg_rst |=> clk_en.timer_two == !($past(bus_wdata[6]) &&
                                                 !$past(timer_two_async_select));
  endproperty
  a_timer_two: assert property (p_timer_two) else $error("timer two enable wrong");

  property p_timers;
    gate_we && !reg_rst |=> clk_en.timer_zero == !$past(bus_wdata[5]) &&
                            clk_en.timer_one == !$past(bus_wdata[3]);
  endproperty
  a_timers: assert property (p_timers) else $error("timer enables wrong");

  property p_reserved;
    bus_re && gate_sel |=> bus_rdata[4] == 1'b0 && bus_rdata == $past(gate_reg);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit not zero");

  property p_serial;
    gate_we && !reg_rst |=> clk_en.serial_peripheral == !$past(bus_wdata[2]) &&
                            clk_en.serial_port == !$past(bus_wdata[1]);
  endproperty
  a_serial: assert property (p_serial) else $error("serial enables wrong");

  property p_converter;
    gate_we && !reg_rst |=> converter_shutdown == $past(bus_wdata[0]) &&
                            comparator_mux_allow == !$past(bus_wdata[0]);
  endproperty
  a_converter: assert property (p_converter) else $error("converter gate wrong");

  property p_release;
    $fell(internal_reset) |-> fetch_start && !$past(any_src) &&
                              $past(cnt_reg) >= $past(len_sel);
  endproperty
  a_release: assert property (p_release) else $error("early reset release");

  property p_sources;
    any_src |=> internal_reset && port_reset && cnt_reg == '0;
  endproperty
  a_sources: assert property (p_sources) else $error("source did not hold reset");

  property p_power_low;
    power_low |-> internal_reset && port_reset;
  endproperty
  a_power_low: assert property (p_power_low) else $error("supply drop not in reset");

  property p_watchdog;
    watchdog_expire && watchdog_reset_mode ##1 !(watchdog_expire && watchdog_reset_mode)
      |-> wdt_src_reg ##1 !wdt_src_reg && internal_reset;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog pulse wrong");

  property p_flag;
    wdt_src_reg && !por_sync |=> status_rd[3];
  endproperty
  a_flag: assert property (p_flag) else $error("watchdog flag not set");

  property p_bandgap;
    1'b1 |=> bandgap_power == $past(brown_enabled | comparator_bandgap_select |
                                    converter_enable);
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap power wrong");

  property p_cov_release;
    $fell(internal_reset);
  endproperty
  c_release: cover property (p_cov_release);

  property p_cov_wdt;
    wdt_src_reg ##1 internal_reset;
  endproperty
  c_wdt: cover property (p_cov_wdt);

  property p_cov_gate;
    gate_we && !reg_rst ##1 !clk_en.timer_zero;
  endproperty
  c_gate: cover property (p_cov_gate);

  property p_cov_brown;
    brown_src ##1 internal_reset;
  endproperty
  c_brown: cover property (p_cov_brown);
endmodule

// >>> rcg_pkg.sv
// Constants, field layout and carrier types of the reset and module clock gating block
package rcg_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CNT_W = 22;

  // Register map
  localparam logic [7:0] GATE_OFFSET = 8'h64;
  localparam logic [7:0] STATUS_OFFSET = 8'h66;
  localparam logic [7:0] GATE_RESET = 8'h00;
  localparam logic [7:0] GATE_WMASK = 8'hEF;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Gate register fields
  localparam int GATE_TWO_WIRE_BIT = 7;
  localparam int GATE_TIMER_TWO_BIT = 6;
  localparam int GATE_TIMER_ZERO_BIT = 5;
  localparam int GATE_RESERVED_BIT = 4;
  localparam int GATE_TIMER_ONE_BIT = 3;
  localparam int GATE_SERIAL_PERIPHERAL_BIT = 2;
  localparam int GATE_SERIAL_PORT_BIT = 1;
  localparam int GATE_CONVERTER_BIT = 0;

  // Status register fields
  localparam int WDT_FLAG_BIT = 3;
  localparam logic STATUS_RESET = 1'b0;

  // Detector level fuse code meaning detector off
  localparam logic [2:0] BROWN_FUSE_OFF = 3'h7;

  // Source filter widths, least times rounded up
  localparam int EXT_MIN_PULSE_NS = 2500;
  localparam int EXT_MIN_CYC = (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BROWN_MIN_NS = 2000;
  localparam int BROWN_MIN_CYC = (BROWN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_MIN_CYC = 1;

  // Delay counter selections by start-up fuse, in microseconds
  localparam int TOUT_US_0 = 16;
  localparam int TOUT_US_1 = 128;
  localparam int TOUT_US_2 = 4096;
  localparam int TOUT_US_3 = 65536;
  localparam int OSC_START_US = 64;
  localparam logic [CNT_W-1:0] OSC_LEN = CNT_W'(OSC_START_US * 1000 / CLK_PERIOD_NS);

  // Per-peripheral clock and register access enables
  typedef struct packed {
    logic two_wire;
    logic timer_two;
    logic timer_zero;
    logic timer_one;
    logic serial_peripheral;
    logic serial_port;
  } rcg_gate_t;

  localparam rcg_gate_t GATE_ALL_ON = 6'h3F;
endpackage

// >>> rcg_filter.sv
// Three-stage synchroniser with a minimum-duration filter for an active-high level
`timescale 1ns/1ns
module rcg_filter #(
  parameter int MIN_CYC = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic raw_in,
  output logic active
);
  logic ff1_reg, ff2_reg, ff3_reg;
  logic [11:0] cnt_reg, cnt_next;
  logic active_reg, active_next;
  localparam logic [11:0] LAST = 12'(MIN_CYC - 1);

  // A level counts only once stages two and three agree
  wire agree = ff2_reg == ff3_reg;
  wire high = agree && ff3_reg;
  assign cnt_next = !agree ? cnt_reg : !ff3_reg ? 12'h000 :
                    (cnt_reg < LAST) ? cnt_reg + 12'h001 : cnt_reg;
  // Short excursions die here before they reach the reset logic
  assign active_next = agree ? (high && cnt_reg >= LAST) : active_reg;

  // Synchroniser chain
  always_ff @(posedge clk) begin
    ff1_reg <= raw_in;
    ff2_reg <= ff1_reg;
    ff3_reg <= ff2_reg;
  end

  // Duration counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= 12'h000;
      active_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      active_reg <= active_next;
    end
  end

  assign active = active_reg;
endmodule

// >>> rcg_top_test.sv
// Self-checking testbench for the reset and module clock gating block
`timescale 1ns/1ns
module rcg_top_test;
  logic clk;
  logic sys_rst;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_we;
  logic bus_re;
  logic [7:0] bus_rdata;
  logic power_low;
  logic ext_reset_n;
  logic external_reset_disable_fuse;
  logic brownout_low;
  logic [2:0] brownout_level_fuse;
  logic [1:0] startup_time_fuse;
  logic [3:0] clock_select_fuse;
  logic watchdog_expire;
  logic watchdog_reset_mode;
  logic timer_two_async_select;
  logic comparator_bandgap_select;
  logic converter_enable;
  rcg_pkg::rcg_gate_t clk_en;
  logic converter_shutdown;
  logic comparator_mux_allow;
  logic bandgap_power;
  logic internal_reset;
  logic port_reset;
  logic fetch_start;
  int miscompares = 0;
  int checks_done = 0;
  int lens [4] = '{4, 8, 16, 32};

  // Short delay lengths keep the run brief; expectations use the same table
  rcg_top #(.TOUT_CYC_0(4), .TOUT_CYC_1(8), .TOUT_CYC_2(16), .TOUT_CYC_3(32)) rcg_top_i (
    .clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata), .power_low(power_low),
    .ext_reset_n(ext_reset_n), .external_reset_disable_fuse(external_reset_disable_fuse),
    .brownout_low(brownout_low), .brownout_level_fuse(brownout_level_fuse),
    .startup_time_fuse(startup_time_fuse), .clock_select_fuse(clock_select_fuse),
    .watchdog_expire(watchdog_expire), .watchdog_reset_mode(watchdog_reset_mode),
    .timer_two_async_select(timer_two_async_select),
    .comparator_bandgap_select(comparator_bandgap_select),
    .converter_enable(converter_enable), .clk_en(clk_en),
    .converter_shutdown(converter_shutdown), .comparator_mux_allow(comparator_mux_allow),
    .bandgap_power(bandgap_power), .internal_reset(internal_reset),
    .port_reset(port_reset), .fetch_start(fetch_start)
  );

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Bus cycles: strobe for one cycle, read data sampled in the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_we <= 1'b1;
    @(posedge clk);
    bus_we <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_re <= 1'b1;
    @(posedge clk);
    bus_re <= 1'b0;
    #1 check(bus_rdata, exp);
    // Read data stand one cycle only
    @(posedge clk);
    #1 check(bus_rdata, 8'h00);
  endtask

  // Waits for the stretched reset to end; the start pulse shares its falling cycle
  task automatic wait_rel;
    int i;
    for (i = 0; i < 3000 && internal_reset !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 3000) begin
      miscompares++;
      conclude();
    end
    check({7'h00, fetch_start}, 8'h01);
  endtask

  // Enables follow the gate value; timer two only gates when synchronous
  task automatic chk_gate(input logic [7:0] g);
    repeat (2) @(posedge clk);
    #1 check({2'h0, clk_en}, {2'h0, ~g[7], ~(g[6] & ~timer_two_async_select), ~g[5], ~g[3],
      ~g[2], ~g[1]});
    check({6'h00, converter_shutdown, comparator_mux_allow}, {6'h00, g[0], ~g[0]});
  endtask

  // Holds one reset source active for n + 1 cycles and checks whether reset followed
  task automatic src_pulse(input int s, input int n, input logic exp);
    logic seen;
    int i;
    seen = 1'b0;
    @(posedge clk);
    case (s)
      0: brownout_low <= 1'b1;
      1: ext_reset_n <= 1'b0;
      2: watchdog_expire <= 1'b1;
      default: power_low <= 1'b1;
    endcase
    #1;
    // A disabled pin must not reach the ports either
    if (s == 1 || s == 3) check({7'h00, port_reset},
      {7'h00, s == 3 || !external_reset_disable_fuse});
    if (s == 3) check({7'h00, internal_reset}, 8'h01);
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      #1 seen = seen | (internal_reset === 1'b1);
    end
    @(posedge clk);
    brownout_low <= 1'b0;
    ext_reset_n <= 1'b1;
    watchdog_expire <= 1'b0;
    power_low <= 1'b0;
    // Stop watching once an expected reset is seen, so its release is not missed
    for (i = 0; i < 8 && !(exp && seen); i++) begin
      @(posedge clk);
      #1 seen = seen | (internal_reset === 1'b1);
    end
    check({7'h00, seen}, {7'h00, exp});
    if (exp) wait_rel();
  endtask

  // Measures the stretched reset after a watchdog pulse for one start-up selection
  task automatic wd_len(input logic [1:0] f, input logic osc);
    int cnt;
    int ext;
    int i;
    cnt = 0;
    ext = osc ? int'(rcg_pkg::OSC_LEN) : 0;
    @(posedge clk);
    startup_time_fuse <= f;
    clock_select_fuse <= {3'h0, osc};
    watchdog_expire <= 1'b1;
    @(posedge clk);
    watchdog_expire <= 1'b0;
    for (i = 0; i < 2000 && !(cnt > 0 && internal_reset === 1'b0); i++) begin
      @(posedge clk);
      #1 if (internal_reset === 1'b1) cnt++;
    end
    if (i == 2000) begin
      miscompares++;
      conclude();
    end
    check(8'(cnt - ext), 8'(lens[f] + 1));
    check(8'((cnt - ext) >>> 8), 8'h00);
    check({7'h00, fetch_start}, 8'h01);
  endtask

  initial begin
    sys_rst = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    bus_we = 1'b0;
    bus_re = 1'b0;
    power_low = 1'b0;
    ext_reset_n = 1'b1;
    external_reset_disable_fuse = 1'b0;
    brownout_low = 1'b0;
    brownout_level_fuse = 3'h0;
    startup_time_fuse = 2'h0;
    clock_select_fuse = 4'h0;
    watchdog_expire = 1'b0;
    watchdog_reset_mode = 1'b1;
    timer_two_async_select = 1'b0;
    comparator_bandgap_select = 1'b0;
    converter_enable = 1'b0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    wait_rel();
    rdchk(rcg_pkg::GATE_OFFSET, rcg_pkg::GATE_RESET);
    chk_gate(8'h00);
    wr(rcg_pkg::GATE_OFFSET, 8'hFF); // converter off, reserved bit not stored
    rdchk(rcg_pkg::GATE_OFFSET, 8'hEF);
    chk_gate(8'hEF);
    @(posedge clk);
    timer_two_async_select <= 1'b1;
    chk_gate(8'hEF);
    @(posedge clk);
    timer_two_async_select <= 1'b0;
    // Each gate bit alone, the reserved one included
    for (int i = 0; i < 8; i++) begin
      wr(rcg_pkg::GATE_OFFSET, 8'h01 << i);
      rdchk(rcg_pkg::GATE_OFFSET, (8'h01 << i) & rcg_pkg::GATE_WMASK);
      chk_gate((8'h01 << i) & rcg_pkg::GATE_WMASK);
    end
    wr(rcg_pkg::GATE_OFFSET, 8'h00);
    chk_gate(8'h00);
    rdchk(8'h65, 8'h00);
    // Reference power for every combination of its three requesters
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      brownout_level_fuse <= k[0] ? 3'h2 : rcg_pkg::BROWN_FUSE_OFF;
      comparator_bandgap_select <= k[1];
      converter_enable <= k[2];
      repeat (2) @(posedge clk);
      #1 check({7'h00, bandgap_power}, {7'h00, k != 0});
    end
    wr(rcg_pkg::GATE_OFFSET, 8'h2A);
    src_pulse(2, 0, 1'b1);
    rdchk(rcg_pkg::GATE_OFFSET, 8'h00);
    rdchk(rcg_pkg::STATUS_OFFSET, 8'h08);
    wr(rcg_pkg::STATUS_OFFSET, 8'h08);
    rdchk(rcg_pkg::STATUS_OFFSET, 8'h08);
    wr(rcg_pkg::STATUS_OFFSET, 8'h00);
    rdchk(rcg_pkg::STATUS_OFFSET, 8'h00);
    @(posedge clk);
    watchdog_reset_mode <= 1'b0;
    src_pulse(2, 0, 1'b0);
    @(posedge clk);
    watchdog_reset_mode <= 1'b1;
    for (int f = 0; f < 4; f++) wd_len(2'(f), 1'b0);
    wd_len(2'h0, 1'b1);
    @(posedge clk);
    startup_time_fuse <= 2'h0;
    clock_select_fuse <= 4'h0;
    brownout_level_fuse <= 3'h0;
    src_pulse(0, 20, 1'b0);
    src_pulse(0, 80, 1'b1);
    @(posedge clk);
    brownout_level_fuse <= rcg_pkg::BROWN_FUSE_OFF;
    src_pulse(0, 80, 1'b0);
    src_pulse(1, 30, 1'b0);
    src_pulse(1, 100, 1'b1);
    @(posedge clk);
    external_reset_disable_fuse <= 1'b1;
    src_pulse(1, 100, 1'b0);
    src_pulse(3, 5, 1'b1);
    conclude();
  end

  // Hang guard
  initial begin
    #3000000;
    miscompares++;
    conclude();
  end
endmodule
